// ---- logic/dscr_config_bank.sv ----
/*
  Write-only configuration register bank of a dual fractional-N synthesizer,
  loaded over a three-wire serial port, with decoded control outputs.
  Assumes the host holds cs_n high for at least five ref_clk periods between
  frames, and that lock and steering inputs come from ref_clk logic.
*/
`timescale 1ns/1ps
module dscr_config_bank (
  input  wire logic        ref_clk,          // Reference clock, 25 MHz
  input  wire logic        rst_n,            // Synchronous reset, active low
  input  wire logic        sclk,             // Serial link clock
  input  wire logic        cs_n,             // Serial frame strobe, active low
  input  wire logic        sdata,            // Serial data
  input  wire logic        main_locked,      // Main loop lock indication
  input  wire logic        main_steer_drive, // Main steering drive level
  input  wire logic        aux_locked,       // Aux loop lock indication
  input  wire logic        aux_steer_drive,  // Aux steering drive level
  output logic [8:0]       main_div_index,   // Main divider index
  output logic [9:0]       main_div_value,   // Main division value
  output logic [17:0]      main_dividend,    // Main dividend, two's complement
  output logic [8:0]       aux_div_index,    // Aux divider index
  output logic [9:0]       aux_div_value,    // Aux division value
  output logic [9:0]       aux_dividend,     // Aux dividend, two's complement
  output logic [5:0]       main_ref_ratio,   // Main reference ratio 1..32
  output logic [5:0]       aux_ref_ratio,    // Aux reference ratio 1..32
  output logic [5:0]       main_pump_steps,  // Main pump current, 31.25 uA units
  output logic [5:0]       aux_pump_steps,   // Aux pump current, 31.25 uA units
  output logic             main_synth_en,    // Main synthesizer powered
  output logic             main_mod_en,      // Main modulator running
  output logic             main_frac10,      // Main modulator in 10-bit mode
  output logic             aux_synth_en,     // Aux synthesizer powered
  output logic             aux_mod_en,       // Aux modulator running
  output logic [2:0]       mux_sel,          // Test multiplexer select
  output logic             mux_tristate,     // Test output tri-stated
  output logic             main_lock_steer_pin_o,  // Main pin output level
  output logic             main_lock_steer_pin_oe, // Main pin drive enable
  output logic             aux_lock_steer_pin_o,   // Aux pin output level
  output logic             aux_lock_steer_pin_oe   // Aux pin drive enable
);

  // ==========================================================================
  // Link side
  // ==========================================================================
  logic [15:0] shift_word;  // Frame bits from the link domain
  logic [4:0]  bit_count;   // Frame length from the link domain
  logic        done_tgl_q;  // Frame consumed, toggles once per frame

  // Link logic runs on sclk; its outputs are stable once cs_n is high
  dscr_link_shift u_link (
    .sclk       (sclk),
    .link_rst_n (rst_n),
    .cs_n       (cs_n),
    .sdata      (sdata),
    .done_tgl   (done_tgl_q),
    .shift_word (shift_word),
    .bit_count  (bit_count)
  );

  // ==========================================================================
  // Strobe synchroniser
  // ==========================================================================
  logic cs_s1_q;   // First stage, read only by the second
  logic cs_s2_q;   // Second stage
  logic cs_s3_q;   // Third stage
  logic cs_lvl_q;  // Filtered strobe level
  logic agree;     // Second and third stages agree
  logic end_evt;   // Frame just ended

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  assign agree   = (cs_s2_q == cs_s3_q);
  assign end_evt = agree && cs_s3_q && !cs_lvl_q;

  // Filtered level; idle is high
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_lvl_q <= 1'b1;
    end else if (agree) begin
      cs_lvl_q <= cs_s3_q;
    end
  end

  // ==========================================================================
  // Frame check and commit
  // ==========================================================================
  logic        commit;     // Good frame, write this cycle
  logic [3:0]  wr_addr;    // Address field of the frame
  logic [11:0] wr_data;    // Data field of the frame

  assign commit  = end_evt && (bit_count == dscr_pkg::FRAME_LEN);
  assign wr_addr = shift_word[dscr_pkg::FRAME_W-1 -: dscr_pkg::ADDR_W];
  assign wr_data = shift_word[dscr_pkg::DATA_W-1:0];

  // Hand the frame back to the link so the next one restarts its count
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      done_tgl_q <= 1'b0;
    end else if (end_evt) begin
      done_tgl_q <= !done_tgl_q;
    end
  end

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [11:0] cfg_q [dscr_pkg::NUM_REGS];  // Configuration words

  // no read path exists; frames to addresses 8 to 15 are dropped
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < dscr_pkg::NUM_REGS; i++) begin
        cfg_q[i] <= dscr_pkg::reset_value(4'(i));
      end
    end else if (commit && (wr_addr <= dscr_pkg::A_LAST)) begin
      cfg_q[wr_addr[2:0]] <= wr_data;
    end
  end

  // ==========================================================================
  // Field decode helpers
  // ==========================================================================
  // Division value from a nine-bit index
  function automatic logic [9:0] div_value(input logic [8:0] idx);
    div_value = {1'b0, idx} + dscr_pkg::DIV_OFFSET;
  endfunction : div_value

  // Ratio or current steps from a five-bit code: code plus one
  function automatic logic [5:0] plus_one(input logic [4:0] code);
    plus_one = {1'b0, code} + dscr_pkg::STEP_ONE;
  endfunction : plus_one

  logic [11:0] r_gain;  // Gain and steering word
  logic [11:0] r_pwr;   // Power and mux word
  logic [11:0] r_ref;   // Reference divider word
  assign r_gain = cfg_q[dscr_pkg::A_GAIN[2:0]];
  assign r_pwr  = cfg_q[dscr_pkg::A_PWR[2:0]];
  assign r_ref  = cfg_q[dscr_pkg::A_REF_DIV[2:0]];

  // ==========================================================================
  // Divider outputs
  // ==========================================================================
  // Registered one cycle behind storage; out-of-range indices pass as written
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      main_div_index <= dscr_pkg::RST_DIV[dscr_pkg::DIV_MSB:0];
      main_div_value <= div_value(dscr_pkg::RST_DIV[dscr_pkg::DIV_MSB:0]);
      aux_div_index  <= dscr_pkg::RST_DIV[dscr_pkg::DIV_MSB:0];
      aux_div_value  <= div_value(dscr_pkg::RST_DIV[dscr_pkg::DIV_MSB:0]);
      aux_dividend   <= 10'h000;
    end else begin
      main_div_index <= cfg_q[dscr_pkg::A_MAIN_DIV[2:0]][dscr_pkg::DIV_MSB:0];
      main_div_value <= div_value(cfg_q[dscr_pkg::A_MAIN_DIV[2:0]][dscr_pkg::DIV_MSB:0]);
      aux_div_index  <= cfg_q[dscr_pkg::A_AUX_DIV[2:0]][dscr_pkg::DIV_MSB:0];
      aux_div_value  <= div_value(cfg_q[dscr_pkg::A_AUX_DIV[2:0]][dscr_pkg::DIV_MSB:0]);
      aux_dividend   <= cfg_q[dscr_pkg::A_AUX_FR[2:0]][dscr_pkg::AUXF_MSB:0];
    end
  end

  // Main dividend; lower byte is forced to zero in 10-bit mode
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      main_dividend <= 18'h00000;
    end else if (r_pwr[dscr_pkg::FRAC10]) begin
      main_dividend <= {cfg_q[dscr_pkg::A_MAIN_FRU[2:0]][dscr_pkg::FRU_MSB:0],
                        dscr_pkg::FRL_PAD};
    end else begin
      main_dividend <= {cfg_q[dscr_pkg::A_MAIN_FRU[2:0]][dscr_pkg::FRU_MSB:0],
                        cfg_q[dscr_pkg::A_MAIN_FRL[2:0]][dscr_pkg::FRL_MSB:0]};
    end
  end

  // ==========================================================================
  // Reference dividers and pump gains
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      main_ref_ratio  <= dscr_pkg::STEP_ONE;
      aux_ref_ratio   <= dscr_pkg::STEP_ONE;
      main_pump_steps <= dscr_pkg::STEP_ONE;
      aux_pump_steps  <= dscr_pkg::STEP_ONE;
    end else begin
      main_ref_ratio  <= plus_one(r_ref[dscr_pkg::REF_MAIN_LSB +: dscr_pkg::FLD5_W]);
      aux_ref_ratio   <= plus_one(r_ref[dscr_pkg::REF_AUX_LSB +: dscr_pkg::FLD5_W]);
      main_pump_steps <= plus_one(r_gain[dscr_pkg::GAIN_MAIN_LSB +: dscr_pkg::FLD5_W]);
      aux_pump_steps  <= plus_one(r_gain[dscr_pkg::GAIN_AUX_LSB +: dscr_pkg::FLD5_W]);
    end
  end

  // ==========================================================================
  // Power and mode
  // ==========================================================================
  // Full power-down overrides both synthesizers; serial port keeps running
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      main_synth_en <= 1'b1;
      main_mod_en   <= 1'b1;
      main_frac10   <= 1'b0;
      aux_synth_en  <= 1'b1;
      aux_mod_en    <= 1'b1;
      mux_sel       <= 3'h0;
      mux_tristate  <= 1'b0;
    end else begin
      main_synth_en <= !(r_pwr[dscr_pkg::PD_FULL] || r_pwr[dscr_pkg::PD_MAIN]);
      main_mod_en   <= !(r_pwr[dscr_pkg::PD_FULL] || r_pwr[dscr_pkg::PD_MAIN]
                         || r_pwr[dscr_pkg::MODE_MAIN]);
      main_frac10   <= r_pwr[dscr_pkg::FRAC10];
      aux_synth_en  <= !(r_pwr[dscr_pkg::PD_FULL] || r_pwr[dscr_pkg::PD_AUX]);
      aux_mod_en    <= !(r_pwr[dscr_pkg::PD_FULL] || r_pwr[dscr_pkg::PD_AUX]
                         || r_pwr[dscr_pkg::MODE_AUX]);
      // Test output stays alive in full power-down
      mux_sel       <= r_pwr[dscr_pkg::MUX_LSB +: dscr_pkg::MUX_W];
      mux_tristate  <= r_pwr[dscr_pkg::MUX_TRI];
    end
  end

  // ==========================================================================
  // Lock and steering pins
  // ==========================================================================
  // Lock mode only pulls low with output level zero; steering mode drives the steering level
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      main_lock_steer_pin_o  <= 1'b0;
      main_lock_steer_pin_oe <= 1'b0;
      aux_lock_steer_pin_o   <= 1'b0;
      aux_lock_steer_pin_oe  <= 1'b0;
    end else begin
      if (r_gain[dscr_pkg::STEER_MAIN]) begin
        main_lock_steer_pin_o  <= main_steer_drive;
        main_lock_steer_pin_oe <= 1'b1;
      end else begin
        main_lock_steer_pin_o  <= 1'b0;
        main_lock_steer_pin_oe <= main_locked;
      end
      if (r_gain[dscr_pkg::STEER_AUX]) begin
        aux_lock_steer_pin_o   <= aux_steer_drive;
        aux_lock_steer_pin_oe  <= 1'b1;
      end else begin
        aux_lock_steer_pin_o   <= 1'b0;
        aux_lock_steer_pin_oe  <= aux_locked;
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_reset_vals: assert property (disable iff (1'b0) !rst_n |=>
    (cfg_q[0] == 12'h006) && (cfg_q[3] == 12'h006) && (cfg_q[5] == 12'h000)
    && (main_div_value == 10'h026)) else $error("reset values wrong");
  chk_commit_len: assert property (end_evt && (bit_count != 5'h10) |=>
    $stable(cfg_q[0]) && $stable(cfg_q[7])) else $error("bad frame committed");
  chk_addr_first: assert property (commit && (wr_addr == 4'h4) |=>
    cfg_q[4] == $past(shift_word[11:0])) else $error("frame field order");
  chk_main_value: assert property (##1 main_div_value ==
    {1'b0, $past(cfg_q[0][8:0])} + 10'h020) else $error("main value");
  chk_aux_value: assert property (##1 aux_div_value ==
    {1'b0, $past(cfg_q[3][8:0])} + 10'h020) else $error("aux value");
  chk_dividend_join: assert property (##1 !$past(r_pwr[3]) |->
    main_dividend == {$past(cfg_q[1][9:0]), $past(cfg_q[2][7:0])})
    else $error("dividend join");
  chk_frac10_pad: assert property (##1 $past(r_pwr[3]) |->
    main_dividend[7:0] == 8'h00 && main_frac10) else $error("10-bit pad");
  chk_ref_ratio: assert property (##1 main_ref_ratio ==
    {1'b0, $past(r_ref[4:0])} + 6'h01) else $error("ref ratio");
  chk_pump_gain: assert property (##1 aux_pump_steps ==
    {1'b0, $past(r_gain[10:6])} + 6'h01) else $error("aux gain");
  chk_main_pin: assert property (##1 !$past(r_gain[5]) |->
    !main_lock_steer_pin_o && main_lock_steer_pin_oe == $past(main_locked))
    else $error("main lock pin");
  chk_aux_pin: assert property (##1 $past(r_gain[11]) |->
    aux_lock_steer_pin_oe && aux_lock_steer_pin_o == $past(aux_steer_drive))
    else $error("aux steer pin");
  chk_full_pd: assert property (r_pwr[0] |=>
    !main_synth_en && !aux_synth_en && !main_mod_en) else $error("full pd");
  chk_main_mode: assert property (r_pwr[2] |=> !main_mod_en)
    else $error("integer mode");
  // Per-synthesizer power-down flags must reach both enables
  chk_main_pd: assert property (r_pwr[1] |=> !main_synth_en && !main_mod_en)
    else $error("main pd");
  chk_aux_pd: assert property (r_pwr[4] |=> !aux_synth_en && !aux_mod_en)
    else $error("aux pd");

  cov_good_frame: cover property (commit);
  cov_short_frame: cover property (end_evt && (bit_count < 5'h10));
  cov_frac10: cover property (commit && (wr_addr == 4'h7) && wr_data[3]);
  cov_steer_on: cover property (main_lock_steer_pin_oe && main_lock_steer_pin_o);
  cov_aux_integer: cover property (aux_synth_en && !aux_mod_en);

endmodule : dscr_config_bank

// ---- common/dscr_pkg.sv ----
/*
  Constants, register addresses, field positions and reset values of the
  dual synthesizer configuration register bank.
  Assumes every file refers to these names as dscr_pkg::name.
*/
package dscr_pkg;

  // ==========================================================================
  // Frame layout
  // ==========================================================================
  localparam int          ADDR_W     = 4;      // Address bits per frame
  localparam int          DATA_W     = 12;     // Data bits per frame
  localparam int          FRAME_W    = 16;     // Whole frame width
  localparam int          CNT_W      = 5;      // Bit counter width
  localparam int          NUM_REGS   = 8;      // Configuration registers held
  localparam logic [4:0]  FRAME_LEN  = 5'h10;  // Bits in a valid frame
  localparam logic [4:0]  CNT_MAX    = 5'h11;  // Saturation: too long
  localparam logic [4:0]  CNT_ONE    = 5'h01;  // Count after a frame's first bit
  localparam logic [4:0]  CNT_ZERO   = 5'h00;  // Count at reset

  // ==========================================================================
  // Register addresses
  // ==========================================================================
  localparam logic [3:0]  A_MAIN_DIV = 4'h0;   // main_integer_divider
  localparam logic [3:0]  A_MAIN_FRU = 4'h1;   // main_fraction_upper
  localparam logic [3:0]  A_MAIN_FRL = 4'h2;   // main_fraction_lower
  localparam logic [3:0]  A_AUX_DIV  = 4'h3;   // aux_integer_divider
  localparam logic [3:0]  A_AUX_FR   = 4'h4;   // aux_fraction
  localparam logic [3:0]  A_REF_DIV  = 4'h5;   // reference_dividers
  localparam logic [3:0]  A_GAIN     = 4'h6;   // detector_gain_steering
  localparam logic [3:0]  A_PWR      = 4'h7;   // powerdown_mux_control
  localparam logic [3:0]  A_LAST     = 4'h7;   // Highest address held here

  // ==========================================================================
  // Reset values and arithmetic constants
  // ==========================================================================
  localparam logic [11:0] RST_ZERO   = 12'h000; // Most registers
  localparam logic [11:0] RST_DIV    = 12'h006; // Both divider registers
  localparam logic [9:0]  DIV_OFFSET = 10'h020; // Division value minus index
  localparam logic [5:0]  STEP_ONE   = 6'h01;   // Ratio and gain step offset
  localparam logic [7:0]  FRL_PAD    = 8'h00;   // Lower dividend in 10-bit mode

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int DIV_MSB       = 8;   // Divider index 8:0
  localparam int FRU_MSB       = 9;   // Upper dividend 9:0
  localparam int FRL_MSB       = 7;   // Lower dividend 7:0
  localparam int AUXF_MSB      = 9;   // Aux dividend 9:0
  localparam int REF_MAIN_LSB  = 0;   // Main reference index 4:0
  localparam int REF_AUX_LSB   = 5;   // Aux reference index 9:5
  localparam int FLD5_W        = 5;   // Width of index and gain fields
  localparam int GAIN_MAIN_LSB = 0;   // Main gain 4:0
  localparam int STEER_MAIN    = 5;   // Main steering enable
  localparam int GAIN_AUX_LSB  = 6;   // Aux gain 10:6
  localparam int STEER_AUX     = 11;  // Aux steering enable
  localparam int PD_FULL       = 0;   // Full power-down
  localparam int PD_MAIN       = 1;   // Main power-down
  localparam int MODE_MAIN     = 2;   // Main integer-N mode
  localparam int FRAC10        = 3;   // Main 10-bit fractionality
  localparam int PD_AUX        = 4;   // Aux power-down
  localparam int MODE_AUX      = 5;   // Aux integer-N mode
  localparam int MUX_LSB       = 6;   // Test mux select 8:6
  localparam int MUX_W         = 3;   // Test mux select width
  localparam int MUX_TRI       = 9;   // Test mux tri-state

  // Reset value by address; both dividers start at a non-zero index
  function automatic logic [11:0] reset_value(input logic [3:0] addr);
    reset_value = ((addr == A_MAIN_DIV) || (addr == A_AUX_DIV)) ? RST_DIV : RST_ZERO;
  endfunction : reset_value

endpackage : dscr_pkg

// ---- logic/dscr_link_shift.sv ----
/*
  Serial-clock side of the configuration port: shifts the frame in, MSB
  first, and counts its bits.
  Assumes the host changes sdata and cs_n away from the rising sclk edge,
  and that sclk may stand still between frames.
*/
`timescale 1ns/1ps
module dscr_link_shift (
  input  wire logic        sclk,        // Serial link clock
  input  wire logic        link_rst_n,  // Asynchronous reset, active low
  input  wire logic        cs_n,        // Frame strobe, active low
  input  wire logic        sdata,       // Serial data
  input  wire logic        done_tgl,    // Toggles when a frame was consumed
  output logic [15:0]      shift_word,  // Last sixteen bits shifted in
  output logic [4:0]       bit_count    // Bits in this frame, saturating
);

  // ==========================================================================
  // Frame start detection
  // ==========================================================================
  logic seen_q;   // Copy of done_tgl taken at a frame's first bit
  logic fresh;    // This edge carries a new frame's first bit

  // done_tgl has stood still since the previous frame ended, so it is
  // quasi-static here; a clock that stops between frames forbids a sync.
  assign fresh = (done_tgl != seen_q);

  // Remember which frame was last started
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      seen_q <= 1'b0;
    end else if (!cs_n) begin
      seen_q <= done_tgl;
    end
  end

  // ==========================================================================
  // Shifter and counter
  // ==========================================================================
  // MSB shifts first
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shift_word <= 16'h0000;
    end else if (!cs_n) begin
      shift_word <= {shift_word[14:0], sdata};
    end
  end

  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_count <= dscr_pkg::CNT_ZERO;
    end else if (!cs_n) begin
      if (fresh) begin
        bit_count <= dscr_pkg::CNT_ONE;
      end else if (bit_count != dscr_pkg::CNT_MAX) begin
        bit_count <= bit_count + dscr_pkg::CNT_ONE;
      end
    end
  end

endmodule : dscr_link_shift

// ---- verification/dscr_host_model.sv ----
/*
  Host end of the three-wire configuration link.
  Assumes the bench calls send() and leaves a gap between frames.
*/
`timescale 1ns/1ps
module dscr_host_model (
  output logic sclk,  // Link clock, still between frames
  output logic cs_n,  // Frame strobe, active low
  output logic sdata  // Serial data
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdata = 1'b0;
  end
  task automatic send(input logic [16:0] w, input int n);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdata = w[i];
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    // Released line must not look valid
    sdata = ~sdata;
  endtask : send
endmodule : dscr_host_model

// ---- verification/dual_synth_config_registers_bench.sv ----
/*
  Self-checking bench of the configuration register bank.
  Assumes decoded outputs settle within eight ref_clk cycles of a frame.
*/
`timescale 1ns/1ps
module dual_synth_config_registers_bench;
  logic ref_clk, rst_n, main_locked, main_steer_drive, aux_locked, aux_steer_drive;
  logic sclk, cs_n, sdata, main_synth_en, main_mod_en, main_frac10, aux_synth_en;
  logic aux_mod_en, mux_tristate, main_lock_steer_pin_o, main_lock_steer_pin_oe;
  logic aux_lock_steer_pin_o, aux_lock_steer_pin_oe;
  logic [8:0] main_div_index, aux_div_index;
  logic [9:0] main_div_value, aux_div_value, aux_dividend;
  logic [17:0] main_dividend;
  logic [5:0] main_ref_ratio, aux_ref_ratio, main_pump_steps, aux_pump_steps;
  logic [2:0] mux_sel;
  int fail_count = 0;
  int n_tests = 0;
  dscr_host_model dscr_host_model_inst (.sclk, .cs_n, .sdata);
  dscr_config_bank dscr_config_bank_inst (.ref_clk, .rst_n, .sclk, .cs_n, .sdata,
    .main_locked, .main_steer_drive, .aux_locked, .aux_steer_drive, .main_div_index,
    .main_div_value, .main_dividend, .aux_div_index, .aux_div_value, .aux_dividend,
    .main_ref_ratio, .aux_ref_ratio, .main_pump_steps, .aux_pump_steps, .main_synth_en,
    .main_mod_en, .main_frac10, .aux_synth_en, .aux_mod_en, .mux_sel, .mux_tristate,
    .main_lock_steer_pin_o, .main_lock_steer_pin_oe, .aux_lock_steer_pin_o,
    .aux_lock_steer_pin_oe);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Frame, then a gap past the resync latency
  task automatic frame(input logic [16:0] w, input int n);
    dscr_host_model_inst.send(w, n);
    repeat (8) @(negedge ref_clk);
  endtask : frame
  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    frame({1'b0, a, d}, 16);
  endtask : wr
  task automatic close_out;
    $display("tests %0d fails %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic t_reset;
    chk("mdiv", 18'h00006, main_div_index);
    chk("aval", 18'h00026, aux_div_value);
    chk("mref", 18'h00001, main_ref_ratio);
    chk("mfr", 18'h00000, main_dividend);
  endtask : t_reset
  task automatic t_div;
    wr(4'h0, 12'h00D);
    chk("mval", 18'h0002D, main_div_value);
    wr(4'h3, 12'h012);
    chk("aval", 18'h00032, aux_div_value);
    chk("aidx", 18'h00012, aux_div_index);
    wr(4'h4, 12'h3FF);
    chk("afr", 18'h003FF, aux_dividend);
  endtask : t_div
  task automatic t_frac;
    wr(4'h1, 12'h07D);
    wr(4'h2, 12'h098);
    chk("mfr", 18'h07D98, main_dividend);
    wr(4'h7, 12'h008);
    chk("mfr10", 18'h07D00, main_dividend);
    chk("f10", 18'h00001, main_frac10);
  endtask : t_frac
  task automatic t_frame;
    frame({1'b0, 4'h0, 12'h111}, 15);
    frame({4'h0, 12'h111, 1'b1}, 17);
    chk("mdiv", 18'h0000D, main_div_index);
  endtask : t_frame
  task automatic t_gain;
    main_locked = 1'b1;
    aux_steer_drive = 1'b1;
    wr(4'h5, 12'h3FF);
    chk("refs", 18'h00820, {main_ref_ratio, aux_ref_ratio});
    wr(4'h6, 12'hFDF);
    chk("pump", 18'h00820, {main_pump_steps, aux_pump_steps});
    chk("mpin", 18'h00001, {main_lock_steer_pin_o, main_lock_steer_pin_oe});
    chk("apin", 18'h00003, {aux_lock_steer_pin_o, aux_lock_steer_pin_oe});
    main_steer_drive = 1'b1;
    aux_locked = 1'b1;
    wr(4'h6, 12'h020);
    chk("mpin2", 18'h00003, {main_lock_steer_pin_o, main_lock_steer_pin_oe});
    chk("apin2", 18'h00001, {aux_lock_steer_pin_o, aux_lock_steer_pin_oe});
  endtask : t_gain
  task automatic t_pwr;
    logic [11:0] c[5] = '{12'h001, 12'h002, 12'h004, 12'h010, 12'h020};
    logic [3:0] e[5] = '{4'h0, 4'h3, 4'hB, 4'hC, 4'hE};
    for (int i = 0; i < 5; i++) begin
      wr(4'h7, c[i]);
      chk("pwr", {14'h0000, e[i]}, {main_synth_en, main_mod_en, aux_synth_en, aux_mod_en});
    end
    wr(4'h7, 12'h3C1);
    chk("mux", 18'h0001E, {mux_tristate, mux_sel, main_synth_en});
  endtask : t_pwr
  initial begin
    rst_n = 1'b0;
    {main_locked, main_steer_drive, aux_locked, aux_steer_drive} = 4'h0;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_reset();
    t_div();
    t_frac();
    t_frame();
    t_gain();
    t_pwr();
    close_out();
  end
  // Watchdog well past the expected run
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
endmodule : dual_synth_config_registers_bench
